// ---- design/aux_power_l2_control.sv ----
// Auxiliary power enable, L2 mode and register retention control.
// Assumes pins from power-on circuitry and an AXI4-Lite master.
//
// How it works
// RQ1: Eight clocks after fundamental reset release, low disable pin clears retained bits.
// RQ2: A high disable pin at the eight-clock sample keeps retained bits.
// RQ3: At 256 clocks the disable pin level becomes the aux power enable bit.
// RQ4: Aux power detected simply mirrors the aux power enable bit.
// RQ5: Software may set aux power enable only with PM event enable set.
// RQ6: L2 mode is enabled when aux detected and PM event enable both hold.
// RQ7: Main power loss enters active standby if aux on and enabled, else inactive.
// RQ8: Ordinary fields clear on every reset kind.
// RQ9: Sticky and lockable fields survive hot and secondary bus resets.
// RQ10: Retained fields survive fundamental, hot and secondary bus resets; the early low sample and entering inactive standby clear them.
// RQ11: External circuitry asserts fundamental reset and sequences the disable pin.
// RQ12: External circuitry holds disable pin high through both samples to keep state.
// RQ13: External circuitry holds disable pin low to disable L2 permanently; software may still set aux enable with PM event enable, enabling L2.
// RQ14: Software setting aux enable leaves the disable pin alone; the pin is only an input.
// RQ15: Aux power serves PM events from D3cold only when PM event enable set.
// RQ16: Active standby gates the core clock; only wake and beacon stay powered.
// RQ17: Post-reset counter restarts on reset; each sample taken once per release.

`timescale 1ns/1ps

module aux_power_l2_control (
  input  wire logic        CLOCK_I,
  input  wire logic        SRST_I,
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        FUNDAMENTAL_RESET_N_I,
  input  wire logic        AUX_POWER_DISABLE_N_I,
  input  wire logic        MAIN_POWER_ON_I,
  input  wire logic        AUX_POWER_ON_I,
  input  wire logic        HOT_RESET_I,
  input  wire logic        SECONDARY_BUS_RESET_I,
  output logic             AUX_POWER_ENABLE_O,
  output logic             AUX_POWER_DETECTED_O,
  output logic             L2_ENABLED_O,
  output logic             PME_AUX_ALLOWED_O,
  output logic             CORE_CLOCK_GATE_O,
  output logic             WAKE_BEACON_POWER_O
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    aux_power_pkg::power_state_type power_state;
    logic                           main_prev;
    logic [8:0]                     post_reset_count;
    logic                           first_done;
    logic                           second_done;
    logic                           retained_init;
    logic                           aux_power_enable;
    logic                           pm_event_enable;
    logic [31:0]                    retained;
    logic [31:0]                    sticky;
    logic [31:0]                    ordinary;
    logic                           unlock;
    logic                           aw_held;
    logic                           w_held;
    logic [7:0]                     aw_addr;
    logic [31:0]                    w_data;
    logic [3:0]                     w_strb;
    logic                           awready;
    logic                           wready;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           arready;
    logic                           rvalid;
    logic [1:0]                     rresp;
    logic [31:0]                    rdata;
    logic                           aux_power_detected;
    logic                           l2_enabled;
    logic                           pme_aux_allowed;
    logic                           clock_gate;
    logic                           wake_beacon_power;
  } control_state_type;

  localparam control_state_type RESET_STATE = '{
    power_state: aux_power_pkg::POWER_ON,
    awready:     1'b1,
    wready:      1'b1,
    arready:     1'b1,
    default:     '0
  };

  control_state_type state;
  control_state_type next_state;

  logic [aux_power_pkg::SYNC_WIDTH-1:0] synced;
  logic                                 fund_reset_n;
  logic                                 disable_n;
  logic                                 main_on;
  logic                                 aux_on;

  // ---------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------
  level_synchroniser pin_sync (
    .clock_i  (CLOCK_I),
    .srst_i   (SRST_I),
    .async_i  ({AUX_POWER_ON_I, MAIN_POWER_ON_I,
                AUX_POWER_DISABLE_N_I, FUNDAMENTAL_RESET_N_I}),
    .stable_o (synced)
  );

  assign fund_reset_n = synced[0];
  assign disable_n    = synced[1];
  assign main_on      = synced[2];
  assign aux_on       = synced[3];

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  strobe
  );
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strobe[i]) begin
        result[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return result;
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr[1:0] == 2'h0) begin
      case (addr)
        aux_power_pkg::SWITCH_CONTROL_OFFSET,
        aux_power_pkg::DEVICE_STATUS_OFFSET,
        aux_power_pkg::RETAINED_OFFSET,
        aux_power_pkg::STICKY_OFFSET,
        aux_power_pkg::ORDINARY_OFFSET,
        aux_power_pkg::LOCK_OFFSET: hit = 1'b1;
        default:                    hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic        write_now;
    logic [31:0] control_word;
    logic [31:0] status_word;
    logic [31:0] written;
    logic [31:0] read_word;

    next_state = state;
    write_now  = 1'b0;
    written    = '0;
    read_word  = '0;

    control_word = '0;
    control_word[aux_power_pkg::CONTROL_AUX_ENABLE_BIT] =
      state.aux_power_enable;
    control_word[aux_power_pkg::CONTROL_PM_EVENT_BIT] = state.pm_event_enable;

    status_word = '0;
    status_word[aux_power_pkg::STATUS_AUX_DETECTED_BIT] =
      state.aux_power_detected;
    status_word[aux_power_pkg::STATUS_L2_ENABLED_BIT] = state.l2_enabled;
    status_word[aux_power_pkg::STATUS_ACTIVE_STBY_BIT] =
      state.power_state == aux_power_pkg::ACTIVE_STANDBY;
    status_word[aux_power_pkg::STATUS_INACTIVE_STBY_BIT] =
      state.power_state == aux_power_pkg::INACTIVE_STANDBY;
    status_word[aux_power_pkg::STATUS_FIRST_DONE_BIT] = state.first_done;
    status_word[aux_power_pkg::STATUS_SECOND_DONE_BIT] = state.second_done;
    status_word[aux_power_pkg::STATUS_RETAINED_INIT_BIT] =
      state.retained_init;
    status_word[aux_power_pkg::STATUS_DISABLE_PIN_BIT] = disable_n;

    // Write address and data are taken in either order
    if (AWVALID_I && state.awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = AWADDR_I;
    end
    if (WVALID_I && state.wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = WDATA_I;
      next_state.w_strb = WSTRB_I;
    end
    if (state.bvalid && BREADY_I) begin
      next_state.bvalid = 1'b0;
    end

    write_now = next_state.aw_held && next_state.w_held && !state.bvalid;
    if (write_now) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = is_mapped(next_state.aw_addr) ?
                           aux_power_pkg::RESP_OKAY :
                           aux_power_pkg::RESP_SLVERR;
      case (next_state.aw_addr)
        aux_power_pkg::SWITCH_CONTROL_OFFSET: begin
          written = merge_bytes(control_word, next_state.w_data,
                                next_state.w_strb);
          next_state.pm_event_enable =
            written[aux_power_pkg::CONTROL_PM_EVENT_BIT];
          next_state.aux_power_enable =
            written[aux_power_pkg::CONTROL_AUX_ENABLE_BIT] &
            written[aux_power_pkg::CONTROL_PM_EVENT_BIT]; // RQ5
        end
        aux_power_pkg::RETAINED_OFFSET: begin
          next_state.retained = merge_bytes(state.retained,
                                            next_state.w_data,
                                            next_state.w_strb);
        end
        aux_power_pkg::STICKY_OFFSET: begin
          written = merge_bytes(state.sticky, next_state.w_data,
                                next_state.w_strb);
          next_state.sticky[aux_power_pkg::LOCKABLE_LOW-1:0] =
            written[aux_power_pkg::LOCKABLE_LOW-1:0];
          // Lockable half ignores writes unless unlocked
          if (state.unlock) begin
            next_state.sticky[31:aux_power_pkg::LOCKABLE_LOW] =
              written[31:aux_power_pkg::LOCKABLE_LOW];
          end
        end
        aux_power_pkg::ORDINARY_OFFSET: begin
          next_state.ordinary = merge_bytes(state.ordinary,
                                            next_state.w_data,
                                            next_state.w_strb);
        end
        aux_power_pkg::LOCK_OFFSET: begin
          written = merge_bytes({31'h0000_0000, state.unlock},
                                next_state.w_data, next_state.w_strb);
          next_state.unlock = written[aux_power_pkg::LOCK_UNLOCK_BIT];
        end
        default: begin
        end
      endcase
    end
    next_state.awready = !next_state.aw_held && !next_state.bvalid;
    next_state.wready  = !next_state.w_held && !next_state.bvalid;

    // Read channel answers one cycle after the address is taken
    case (ARADDR_I)
      aux_power_pkg::SWITCH_CONTROL_OFFSET: read_word = control_word;
      aux_power_pkg::DEVICE_STATUS_OFFSET:  read_word = status_word;
      aux_power_pkg::RETAINED_OFFSET:       read_word = state.retained;
      aux_power_pkg::STICKY_OFFSET:         read_word = state.sticky;
      aux_power_pkg::ORDINARY_OFFSET:       read_word = state.ordinary;
      aux_power_pkg::LOCK_OFFSET:
        read_word = {31'h0000_0000, state.unlock};
    endcase
    if (ARVALID_I && state.arready) begin
      next_state.arready = 1'b0;
      next_state.rvalid  = 1'b1;
      next_state.rdata   = is_mapped(ARADDR_I) ? read_word : '0;
      next_state.rresp   = is_mapped(ARADDR_I) ?
                           aux_power_pkg::RESP_OKAY :
                           aux_power_pkg::RESP_SLVERR;
    end else if (state.rvalid && RREADY_I) begin
      next_state.rvalid  = 1'b0;
      next_state.arready = 1'b1;
    end

    // Reset classes override software writes in the same cycle
    if (!fund_reset_n || HOT_RESET_I || SECONDARY_BUS_RESET_I) begin
      next_state.ordinary = aux_power_pkg::ORDINARY_RESET; // RQ8
      next_state.unlock   = 1'b0; // RQ8
    end
    // Hot and secondary bus resets leave the sticky class alone
    if (!fund_reset_n) begin
      next_state.sticky          = aux_power_pkg::STICKY_RESET; // RQ9
      next_state.pm_event_enable = 1'b0; // RQ9
    end

    // Post-reset sampling of the disable pin; counting starts once the
    // synchronised release is seen, so the pin must settle beforehand
    if (!fund_reset_n) begin
      next_state.post_reset_count = '0; // RQ17
      next_state.first_done       = 1'b0; // RQ17
      next_state.second_done      = 1'b0; // RQ17
    end else begin
      if (state.post_reset_count != aux_power_pkg::SECOND_SAMPLE_CLOCKS) begin
        next_state.post_reset_count =
          aux_power_pkg::COUNT_WIDTH'(state.post_reset_count + 9'h001);
      end
      if (state.post_reset_count == aux_power_pkg::FIRST_SAMPLE_CLOCKS &&
          !state.first_done) begin
        next_state.first_done = 1'b1; // RQ17
        if (!disable_n) begin
          next_state.retained      = aux_power_pkg::RETAINED_RESET; // RQ1
          next_state.retained_init = 1'b1; // RQ1 RQ10
        end else begin
          next_state.retained_init = 1'b0; // RQ2
        end
      end
      // Sample wins over a software write landing in the same cycle
      if (state.post_reset_count == aux_power_pkg::SECOND_SAMPLE_CLOCKS &&
          !state.second_done) begin
        next_state.second_done      = 1'b1; // RQ17
        next_state.aux_power_enable = disable_n; // RQ3
      end
    end

    // Standby selection on loss of main power
    next_state.main_prev = main_on;
    unique case (state.power_state)
      aux_power_pkg::POWER_ON: begin
        if (state.main_prev && !main_on) begin
          if (aux_on && state.aux_power_enable) begin
            next_state.power_state = aux_power_pkg::ACTIVE_STANDBY; // RQ7
          end else begin
            next_state.power_state = aux_power_pkg::INACTIVE_STANDBY; // RQ7
            next_state.retained    = aux_power_pkg::RETAINED_RESET; // RQ7
          end
        end
      end
      aux_power_pkg::ACTIVE_STANDBY: begin
        if (main_on) begin
          next_state.power_state = aux_power_pkg::POWER_ON;
        end else if (!aux_on) begin
          // Losing aux too means nothing held the saved context
          next_state.power_state = aux_power_pkg::INACTIVE_STANDBY;
          next_state.retained    = aux_power_pkg::RETAINED_RESET;
        end
      end
      aux_power_pkg::INACTIVE_STANDBY: begin
        if (main_on) begin
          next_state.power_state = aux_power_pkg::POWER_ON;
        end
      end
      default: begin
        next_state.power_state = aux_power_pkg::POWER_ON;
      end
    endcase

    // Derived outputs
    next_state.clock_gate =
      next_state.power_state == aux_power_pkg::ACTIVE_STANDBY; // RQ16
    next_state.wake_beacon_power =
      next_state.power_state == aux_power_pkg::ACTIVE_STANDBY; // RQ7
    // No supply pin is sensed here
    next_state.aux_power_detected = next_state.aux_power_enable; // RQ4
    next_state.l2_enabled = next_state.aux_power_detected &
                            next_state.pm_event_enable; // RQ6
    next_state.pme_aux_allowed = next_state.l2_enabled & aux_on; // RQ15
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign AWREADY_O            = state.awready;
  assign WREADY_O             = state.wready;
  assign BVALID_O             = state.bvalid;
  assign BRESP_O              = state.bresp;
  assign ARREADY_O            = state.arready;
  assign RVALID_O             = state.rvalid;
  assign RDATA_O              = state.rdata;
  assign RRESP_O              = state.rresp;
  assign AUX_POWER_ENABLE_O   = state.aux_power_enable;
  assign AUX_POWER_DETECTED_O = state.aux_power_detected;
  assign L2_ENABLED_O         = state.l2_enabled;
  assign PME_AUX_ALLOWED_O    = state.pme_aux_allowed;
  assign CORE_CLOCK_GATE_O    = state.clock_gate;
  assign WAKE_BEACON_POWER_O  = state.wake_beacon_power;

endmodule

// ---- design/aux_power_pkg.sv ----
// Constants shared by the auxiliary power / L2 mode controller.
// Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register port.

package aux_power_pkg;

  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] SWITCH_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] DEVICE_STATUS_OFFSET  = 8'h04;
  localparam logic [7:0] RETAINED_OFFSET       = 8'h08;
  localparam logic [7:0] STICKY_OFFSET         = 8'h0C;
  localparam logic [7:0] ORDINARY_OFFSET       = 8'h10;
  localparam logic [7:0] LOCK_OFFSET           = 8'h14;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CONTROL_AUX_ENABLE_BIT = 0;
  localparam int CONTROL_PM_EVENT_BIT   = 1;

  localparam int STATUS_AUX_DETECTED_BIT = 0;
  localparam int STATUS_L2_ENABLED_BIT   = 1;
  localparam int STATUS_ACTIVE_STBY_BIT  = 2;
  localparam int STATUS_INACTIVE_STBY_BIT = 3;
  localparam int STATUS_FIRST_DONE_BIT   = 4;
  localparam int STATUS_SECOND_DONE_BIT  = 5;
  localparam int STATUS_RETAINED_INIT_BIT = 6;
  localparam int STATUS_DISABLE_PIN_BIT  = 7;

  localparam int LOCK_UNLOCK_BIT = 0;
  localparam int LOCKABLE_LOW    = 16;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [31:0] RETAINED_RESET = 32'h0000_0000;
  localparam logic [31:0] STICKY_RESET   = 32'h0000_0000;
  localparam logic [31:0] ORDINARY_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int         COUNT_WIDTH          = 9;
  localparam logic [8:0] FIRST_SAMPLE_CLOCKS  = 9'h008;
  localparam logic [8:0] SECOND_SAMPLE_CLOCKS = 9'h100;
  localparam int         SYNC_WIDTH           = 4;

  // ---------------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    POWER_ON         = 3'b001,
    ACTIVE_STANDBY   = 3'b010,
    INACTIVE_STANDBY = 3'b100
  } power_state_type;

endpackage

// ---- design/level_synchroniser.sv ----
// Three-stage synchroniser for the asynchronous power and reset pins.
// Assumes inputs that change slowly compared with the core clock.

`timescale 1ns/1ps

module level_synchroniser (
  input  wire logic                                 clock_i,
  input  wire logic                                 srst_i,
  input  wire logic [aux_power_pkg::SYNC_WIDTH-1:0] async_i,
  output logic      [aux_power_pkg::SYNC_WIDTH-1:0] stable_o
);

  typedef struct packed {
    logic [aux_power_pkg::SYNC_WIDTH-1:0] first;
    logic [aux_power_pkg::SYNC_WIDTH-1:0] second;
    logic [aux_power_pkg::SYNC_WIDTH-1:0] third;
    logic [aux_power_pkg::SYNC_WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  // ---------------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------------
  // The first stage feeds only the second; a bit is accepted once the
  // second and third stages agree, which filters a one-cycle glitch.
  always_comb begin
    logic [aux_power_pkg::SYNC_WIDTH-1:0] agree;
    agree             = ~(state.second ^ state.third);
    next_state        = state;
    next_state.first  = async_i;
    next_state.second = state.first;
    next_state.third  = state.second;
    next_state.stable = (state.second & agree) | (state.stable & ~agree);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign stable_o = state.stable;

endmodule

// ---- test/aux_power_chk.sv ----
// Checker for the aux power / L2 controller, bound to its top ports.
// Assumes the core clock and the synchronous reset of the top module.
`timescale 1ns/1ps
module aux_power_chk (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic FUNDAMENTAL_RESET_N_I,
  input wire logic MAIN_POWER_ON_I,
  input wire logic AUX_POWER_ON_I,
  input wire logic BVALID_O,
  input wire logic AUX_POWER_ENABLE_O,
  input wire logic AUX_POWER_DETECTED_O,
  input wire logic L2_ENABLED_O,
  input wire logic PME_AUX_ALLOWED_O,
  input wire logic CORE_CLOCK_GATE_O,
  input wire logic WAKE_BEACON_POWER_O
);
  // ------------------------------------------------------------
  // Edges since release of the pin; pin passes a synchroniser
  // ------------------------------------------------------------
  logic [9:0] since;
  always_ff @(posedge CLOCK_I)
    since <= (SRST_I || !FUNDAMENTAL_RESET_N_I) ? 10'h000
           : since + {9'h000, since != 10'h3FF};
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  sample_moment_a: assert property ($changed(AUX_POWER_ENABLE_O) && !BVALID_O
    |-> since inside {[256:268]}) else $error("enable changed off sample");
  detect_source_a: assert property (AUX_POWER_DETECTED_O
    == AUX_POWER_ENABLE_O) else $error("detect without enable");
  l2_needs_detect_a: assert property (L2_ENABLED_O
    |-> AUX_POWER_DETECTED_O || $past(AUX_POWER_DETECTED_O)) else $error("l2");
  pme_needs_l2_a: assert property (PME_AUX_ALLOWED_O
    |-> L2_ENABLED_O || $past(L2_ENABLED_O)) else $error("pme aux");
  gate_with_wake_a: assert property (CORE_CLOCK_GATE_O
    |-> WAKE_BEACON_POWER_O) else $error("gate without wake");
  standby_enabled_a: assert property ($rose(CORE_CLOCK_GATE_O)
    |-> AUX_POWER_ENABLE_O && AUX_POWER_ON_I) else $error("standby cause");
  standby_main_off_a: assert property ($rose(WAKE_BEACON_POWER_O)
    |-> !MAIN_POWER_ON_I) else $error("standby with main");
  reset_clears_a: assert property (disable iff (1'b0) SRST_I
    |=> !AUX_POWER_ENABLE_O && !BVALID_O) else $error("reset state");
  cover property ($rose(CORE_CLOCK_GATE_O));
  cover property ($rose(L2_ENABLED_O));
  cover property ($fell(AUX_POWER_ENABLE_O));
endmodule
bind aux_power_l2_control aux_power_chk chk (.CLOCK_I, .SRST_I,
  .FUNDAMENTAL_RESET_N_I, .MAIN_POWER_ON_I, .AUX_POWER_ON_I, .BVALID_O,
  .AUX_POWER_ENABLE_O, .AUX_POWER_DETECTED_O, .L2_ENABLED_O,
  .PME_AUX_ALLOWED_O, .CORE_CLOCK_GATE_O, .WAKE_BEACON_POWER_O);

// ---- test/power_supply_model.sv ----
// Power-on circuitry model: supplies, fundamental reset, disable pin.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module power_supply_model (
  input  wire logic clock_i,
  output logic      reset_n_o,
  output logic      disable_n_o,
  output logic      main_o,
  output logic      aux_o
);
  initial {reset_n_o, disable_n_o, main_o, aux_o} = 4'h3;
  // Pin changes between the two samples, never at either one
  task automatic cycle(input logic early, input logic late);
    reset_n_o <= 1'b0;
    disable_n_o <= early;
    repeat (6) @(posedge clock_i);
    reset_n_o <= 1'b1;
    repeat (120) @(posedge clock_i);
    disable_n_o <= late;
    repeat (200) @(posedge clock_i);
  endtask
  task automatic supply(input logic main, input logic aux);
    main_o <= main;
    aux_o <= aux;
    repeat (8) @(posedge clock_i);
  endtask
endmodule

// ---- test/aux_power_l2_mode_control_test.sv ----
// Self-checking bench: bus tasks note results, a monitor compares.
// Assumes the power model above on the far side of the pins.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s exp %h got %h", n, e, g); end end
module aux_power_l2_mode_control_test;
  logic CLOCK_I = 0, SRST_I = 1, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0;
  logic ARVALID_I = 0, RREADY_I = 0, HOT_RESET_I = 0;
  logic SECONDARY_BUS_RESET_I = 0, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O;
  logic RVALID_O, AUX_POWER_ENABLE_O, AUX_POWER_DETECTED_O, L2_ENABLED_O;
  logic PME_AUX_ALLOWED_O, CORE_CLOCK_GATE_O, WAKE_BEACON_POWER_O;
  logic FUNDAMENTAL_RESET_N_I, AUX_POWER_DISABLE_N_I;
  logic MAIN_POWER_ON_I, AUX_POWER_ON_I;
  logic [7:0] AWADDR_I = 0, ARADDR_I = 0;
  logic [31:0] WDATA_I = 0, RDATA_O, r, s;
  logic [3:0] WSTRB_I = 4'hF;
  logic [1:0] BRESP_O, RRESP_O, eb, bq[$];
  logic [33:0] er, rq[$];
  int mismatches = 0, tests_run = 0;
  aux_power_l2_control dut (.*);
  power_supply_model psu (.clock_i(CLOCK_I), .reset_n_o(FUNDAMENTAL_RESET_N_I),
    .disable_n_o(AUX_POWER_DISABLE_N_I), .main_o(MAIN_POWER_ON_I),
    .aux_o(AUX_POWER_ON_I));
  always #4 CLOCK_I = ~CLOCK_I;
  function automatic logic [1:0] resp(input logic [7:0] a);
    return a > aux_power_pkg::LOCK_OFFSET ? aux_power_pkg::RESP_SLVERR
                                         : aux_power_pkg::RESP_OKAY;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 1, w = 1;
    bq.push_back(resp(a));
    AWADDR_I <= a; WDATA_I <= d; AWVALID_I <= 1; WVALID_I <= 1; BREADY_I <= 1;
    while (aw || w) begin
      @(posedge CLOCK_I);
      if (AWREADY_O) begin aw = 0; AWVALID_I <= 0; end
      if (WREADY_O) begin w = 0; WVALID_I <= 0; end
    end
    do @(posedge CLOCK_I); while (!BVALID_O);
    BREADY_I <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back({resp(a), e});
    ARADDR_I <= a; ARVALID_I <= 1; RREADY_I <= 1;
    do @(posedge CLOCK_I); while (!ARREADY_O);
    ARVALID_I <= 0;
    do @(posedge CLOCK_I); while (!RVALID_O);
    RREADY_I <= 0;
  endtask
  always @(posedge CLOCK_I) begin
    if (BVALID_O && BREADY_I) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, BRESP_O)
    end
    if (RVALID_O && RREADY_I) begin
      er = rq.pop_front();
      `CHK("read", er, {RRESP_O, RDATA_O})
    end
  end
  task automatic summarize;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Generous: the run needs about 1100 cycles
  initial begin repeat (20000) @(posedge CLOCK_I); mismatches++; summarize; end
  initial begin
    void'($urandom(32'h3a7d46d4));
    repeat (8) @(posedge CLOCK_I);
    SRST_I <= 0;
    @(posedge CLOCK_I);
    rd(aux_power_pkg::ORDINARY_OFFSET, 0);
    rd(8'h40, 0);
    r = $urandom; s = $urandom;
    wr(aux_power_pkg::RETAINED_OFFSET, r);
    psu.cycle(0, 1);
    `CHK("enable", 1'b1, AUX_POWER_ENABLE_O)
    `CHK("detected", 1'b1, AUX_POWER_DETECTED_O)
    rd(aux_power_pkg::DEVICE_STATUS_OFFSET, 32'h0000_00F1);
    rd(aux_power_pkg::RETAINED_OFFSET, 0);
    wr(aux_power_pkg::RETAINED_OFFSET, r);
    wr(aux_power_pkg::ORDINARY_OFFSET, s);
    psu.cycle(1, 1);
    rd(aux_power_pkg::RETAINED_OFFSET, r);
    rd(aux_power_pkg::ORDINARY_OFFSET, 0);
    wr(aux_power_pkg::LOCK_OFFSET, 1);
    wr(aux_power_pkg::STICKY_OFFSET, s);
    for (int k = 1; k < 3; k++) begin
      wr(aux_power_pkg::ORDINARY_OFFSET, s);
      {SECONDARY_BUS_RESET_I, HOT_RESET_I} <= k[1:0];
      @(posedge CLOCK_I);
      {SECONDARY_BUS_RESET_I, HOT_RESET_I} <= 2'h0;
      @(posedge CLOCK_I);
      rd(aux_power_pkg::ORDINARY_OFFSET, 0);
      rd(aux_power_pkg::STICKY_OFFSET, s);
      rd(aux_power_pkg::RETAINED_OFFSET, r);
    end
    wr(aux_power_pkg::SWITCH_CONTROL_OFFSET, 0);
    wr(aux_power_pkg::SWITCH_CONTROL_OFFSET, 1);
    `CHK("enable", 1'b0, AUX_POWER_ENABLE_O)
    wr(aux_power_pkg::SWITCH_CONTROL_OFFSET, 3);
    repeat (3) @(posedge CLOCK_I);
    `CHK("l2", 1'b1, L2_ENABLED_O)
    `CHK("pme", 1'b1, PME_AUX_ALLOWED_O)
    psu.supply(0, 1);
    `CHK("gate", 1'b1, CORE_CLOCK_GATE_O)
    psu.supply(1, 1);
    rd(aux_power_pkg::RETAINED_OFFSET, r);
    wr(aux_power_pkg::SWITCH_CONTROL_OFFSET, 2);
    psu.supply(0, 1);
    `CHK("wake", 1'b0, WAKE_BEACON_POWER_O)
    psu.supply(1, 1);
    rd(aux_power_pkg::RETAINED_OFFSET, 0);
    wr(aux_power_pkg::SWITCH_CONTROL_OFFSET, 3);
    psu.cycle(0, 0);
    `CHK("enable", 1'b0, AUX_POWER_ENABLE_O)
    summarize;
  end
endmodule
